// [cmic_pkg.sv]
package cmic_pkg;
  // =====================================================
  // register map (byte offsets on the control port)
  localparam logic [7:0] CMIC_OFS_STATUS = 8'h00;
  localparam logic [7:0] CMIC_OFS_INBUF = 8'h04;
  localparam logic [7:0] CMIC_OFS_MODE = 8'h08;
  localparam logic [7:0] CMIC_OFS_FREQ = 8'h0c;
  localparam logic [7:0] CMIC_OFS_ODRV = 8'h10;
  // =====================================================
  // status fields
  localparam int CMIC_ST_CAL_DONE = 0;
  localparam int CMIC_ST_CAL_FAIL = 1;
  localparam int CMIC_ST_SEQ_DONE = 2;
  localparam int CMIC_ST_OUTS_ON = 3;
  localparam int CMIC_ST_JA = 4;
  // =====================================================
  // input_buffer_config fields
  localparam int CMIC_IB_CMOS_SEL = 0;
  localparam int CMIC_IB_LVDS = 1;
  localparam int CMIC_IB_HCSL = 2;
  localparam int CMIC_IB_SELFBIAS = 3;
  localparam int CMIC_IB_DCBIAS = 4;
  localparam int CMIC_IB_INBUFF = 5;
  localparam int CMIC_IB_W = 6;
  localparam logic [5:0] CMIC_IB_RST = 6'h00;
  // =====================================================
  // mode control fields
  localparam int CMIC_MD_STARTUP = 0;
  localparam int CMIC_MD_LOCK_SEL = 2;
  localparam int CMIC_MD_DPLL_EN = 3;
  localparam int CMIC_MD_REF_SEL = 4;
  localparam int CMIC_MD_W = 5;
  localparam logic [4:0] CMIC_MD_RST = 5'h00;
  localparam logic [1:0] CMIC_SU_APLL = 2'h0;
  localparam logic [1:0] CMIC_SU_DPLL = 2'h1;
  localparam logic [1:0] CMIC_SU_NOW = 2'h2;
  // =====================================================
  // output_driver_mode_config: 2-bit mode per output, then term enables
  localparam int CMIC_NOUT = 4;
  localparam int CMIC_OD_TERM = 8;
  localparam int CMIC_OD_W = 12;
  localparam logic [11:0] CMIC_OD_RST = 12'h000;
  localparam logic [1:0] CMIC_OM_HIZ = 2'h0;
  localparam logic [1:0] CMIC_OM_HCSL = 2'h1;
  localparam logic [1:0] CMIC_OM_LVDS = 2'h2;
  localparam logic [1:0] CMIC_OM_CMOS = 2'h3;
  // =====================================================
  // timing and widths
  localparam int CMIC_CLK_MHZ = 40;
  localparam int CMIC_REL_GAP_NS = 100;
  localparam int CMIC_REL_GAP_CYC = (CMIC_REL_GAP_NS * CMIC_CLK_MHZ + 999) / 1000;
  localparam int CMIC_AW = 8;
  localparam int CMIC_DW = 32;
  localparam logic [31:0] CMIC_FREQ_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    CMIC_S_PWR, CMIC_S_REL, CMIC_S_CAL, CMIC_S_LOAD, CMIC_S_WAIT, CMIC_S_RUN
  } cmic_seq_e;
  typedef enum logic [2:0] {
    CMIC_H_IDLE, CMIC_H_BUSY, CMIC_H_IB, CMIC_H_MD, CMIC_H_OD
  } cmic_host_e;
endpackage

// [cmic_if.sv]
interface cmic_if;
  import cmic_pkg::*;
  logic req;
  logic we;
  logic [CMIC_AW-1:0] addr;
  logic [CMIC_DW-1:0] wdata;
  logic ack;
  logic [CMIC_DW-1:0] rdata;
  modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// [cmic_dev.sv]
// Functional notes
// - all blocks held reset until regulators stable
// - blocks released one after another
// - bias calibration sets done status bit
// - calibration failure flagged, startup continues
// - calibration bits readable over port
// - select bit picks differential or single-ended
// - host sets bias bit for ac-coupled input
// - input pad off at reset, host enables
// - lvds closes switch a, hcsl switch c
// - term enable switches output source resistor
// - host frequency word passed to analog loop
// - word scaled by feedback divide ratio
// - fixed crystal trim offset added
// - synth mode ignores reference, bypasses digital loop
// - jitter mode steers loop from digital filter
// - jitter mode blocks host frequency word
// - reset defaults give synthesizer mode
// - host programs four controls for jitter mode
// - synth reference is crystal or ref pins
// - unused single-ended output set high impedance
// - ac-coupled output uses hcsl and swing
// - startup policy gates outputs until lock
module cmic_dev #(
  parameter int NBLK = 4,
  parameter int FW = 32,
  parameter int DIVW = 16,
  parameter int SCALE_SH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  cmic_if.dev bus,
  input wire logic reg_stable,
  output logic [NBLK-1:0] blk_rst,
  output logic bias_cal_start,
  input wire logic bias_cal_ready,
  input wire logic bias_cal_error,
  input wire logic cfg_load_done,
  input wire logic apll_lock,
  input wire logic dpll_lock,
  input wire logic [DIVW-1:0] fb_div_ratio,
  input wire logic [FW-1:0] xtal_trim,
  input wire logic [FW-1:0] dpll_steer,
  output logic [FW-1:0] fb_word,
  output logic ref_pad_en,
  output logic ref_single_ended,
  output logic ref_sw_a,
  output logic ref_sw_c,
  output logic ref_selfbias,
  output logic diff_ac_bias_enable,
  output logic apll_ref_sel,
  output logic dpll_active,
  output logic lock_sel,
  output logic outputs_enabled,
  output logic [2*cmic_pkg::CMIC_NOUT-1:0] out_mode,
  output logic [cmic_pkg::CMIC_NOUT-1:0] hcsl_term
);
  import cmic_pkg::*;

  typedef struct packed {
    cmic_seq_e st;
    logic [NBLK-1:0] rel;
    logic [7:0] gap;
    logic cal_done;
    logic cal_fail;
    logic outs_on;
    logic [CMIC_IB_W-1:0] ibc;
    logic [CMIC_MD_W-1:0] mode;
    logic [CMIC_OD_W-1:0] odm;
    logic [FW-1:0] fcw;
    logic [FW-1:0] fbw;
    logic ack;
    logic [CMIC_DW-1:0] rdata;
  } cmic_dev_s;

  cmic_dev_s q;
  cmic_dev_s d;
  logic take;
  logic ja_mode;
  logic [FW+DIVW-1:0] prod;
  logic [FW-1:0] scaled;

  // =====================================================
  // mode decode
  // a single registered bit selects the mode, so a write never glitches it
  // registered mode select
  assign ja_mode = q.mode[CMIC_MD_DPLL_EN];
  assign take = bus.req && !q.ack;
  assign prod = q.fcw * fb_div_ratio;
  assign scaled = prod[SCALE_SH +: FW];

  // =====================================================
  // next state
  always_comb begin
    d = q;
    d.ack = 1'b0;
    case (q.st)
      CMIC_S_PWR: begin
        if (reg_stable) begin
          d.st = CMIC_S_REL;
          d.gap = 8'h00;
        end
      end
      CMIC_S_REL: begin
        if (d.gap == 8'(CMIC_REL_GAP_CYC)) begin
          d.gap = 8'h00;
          d.rel = {q.rel[NBLK-2:0], 1'b1};
          if (q.rel[NBLK-1]) begin
            d.st = CMIC_S_CAL;
          end
        end else begin
          d.gap = q.gap + 8'h01;
        end
      end
      CMIC_S_CAL: begin
        if (bias_cal_ready) begin
          d.cal_done = 1'b1;
          d.cal_fail = bias_cal_error;
          d.st = CMIC_S_LOAD;
        end
      end
      CMIC_S_LOAD: begin
        if (cfg_load_done) begin
          d.st = CMIC_S_WAIT;
        end
      end
      CMIC_S_WAIT: begin
        if ((q.mode[CMIC_MD_STARTUP +: 2] == CMIC_SU_APLL && apll_lock) ||
            (q.mode[CMIC_MD_STARTUP +: 2] == CMIC_SU_DPLL && dpll_lock) ||
            q.mode[CMIC_MD_STARTUP +: 2] == CMIC_SU_NOW) begin
          d.outs_on = 1'b1;
          d.st = CMIC_S_RUN;
        end
      end
      default: begin
        d.st = CMIC_S_RUN;
      end
    endcase
    // register port; writes apply on the next edge in this clock domain
    if (take) begin
      d.ack = 1'b1;
      d.rdata = '0;
      if (bus.addr == CMIC_OFS_STATUS) begin
        d.rdata[CMIC_ST_CAL_DONE] = q.cal_done;
        d.rdata[CMIC_ST_CAL_FAIL] = q.cal_fail;
        d.rdata[CMIC_ST_SEQ_DONE] = (q.st == CMIC_S_RUN);
        d.rdata[CMIC_ST_OUTS_ON] = q.outs_on;
        d.rdata[CMIC_ST_JA] = ja_mode;
      end else if (bus.addr == CMIC_OFS_INBUF) begin
        d.rdata[CMIC_IB_W-1:0] = q.ibc;
        if (bus.we) begin
          d.ibc = bus.wdata[CMIC_IB_W-1:0];
        end
      end else if (bus.addr == CMIC_OFS_MODE) begin
        d.rdata[CMIC_MD_W-1:0] = q.mode;
        if (bus.we) begin
          d.mode = bus.wdata[CMIC_MD_W-1:0];
        end
      end else if (bus.addr == CMIC_OFS_FREQ) begin
        d.rdata[FW-1:0] = q.fcw;
        if (bus.we) begin
          d.fcw = bus.wdata[FW-1:0];
        end
      end else if (bus.addr == CMIC_OFS_ODRV) begin
        d.rdata[CMIC_OD_W-1:0] = q.odm;
        if (bus.we) begin
          d.odm = bus.wdata[CMIC_OD_W-1:0];
        end
      end
    end
    // block host word in jitter mode
    if (ja_mode) begin
      d.fbw = dpll_steer;
    end else begin
      d.fbw = scaled + xtal_trim;
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q.st <= CMIC_S_PWR;
      q.rel <= '0;
      q.gap <= 8'h00;
      q.cal_done <= 1'b0;
      q.cal_fail <= 1'b0;
      q.outs_on <= 1'b0;
      q.ibc <= CMIC_IB_RST;
      q.mode <= CMIC_MD_RST;
      q.odm <= CMIC_OD_RST;
      q.fcw <= CMIC_FREQ_RST[FW-1:0];
      q.fbw <= '0;
      q.ack <= 1'b0;
      q.rdata <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // =====================================================
  // outputs
  assign blk_rst = ~q.rel;
  assign bias_cal_start = (q.st == CMIC_S_CAL);
  assign fb_word = q.fbw;
  assign bus.ack = q.ack;
  assign bus.rdata = q.rdata;
  assign ref_pad_en = q.ibc[CMIC_IB_INBUFF];
  assign ref_single_ended = q.ibc[CMIC_IB_CMOS_SEL];
  assign ref_sw_a = q.ibc[CMIC_IB_LVDS];
  assign ref_sw_c = q.ibc[CMIC_IB_HCSL];
  assign ref_selfbias = q.ibc[CMIC_IB_SELFBIAS];
  assign diff_ac_bias_enable = q.ibc[CMIC_IB_DCBIAS];
  assign apll_ref_sel = q.mode[CMIC_MD_REF_SEL];
  // digital loop bypassed and gated off outside jitter mode
  assign dpll_active = ja_mode;
  assign lock_sel = q.mode[CMIC_MD_LOCK_SEL];
  assign outputs_enabled = q.outs_on;
  assign out_mode = q.odm[2*CMIC_NOUT-1:0];
  assign hcsl_term = q.odm[CMIC_OD_TERM +: CMIC_NOUT];
endmodule

// [cmic_host.sv]
module cmic_host (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  cmic_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_we,
  input wire logic [cmic_pkg::CMIC_AW-1:0] cmd_addr,
  input wire logic [cmic_pkg::CMIC_DW-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [cmic_pkg::CMIC_DW-1:0] rsp_rdata,
  input wire logic setup_ja,
  input wire logic ja_single_ended,
  input wire logic ja_ac_coupled,
  input wire logic ja_lvds,
  input wire logic [1:0] ja_startup,
  input wire logic [cmic_pkg::CMIC_NOUT-1:0] out_unused,
  input wire logic [cmic_pkg::CMIC_NOUT-1:0] out_ac_coupled,
  input wire logic [cmic_pkg::CMIC_NOUT-1:0] out_term
);
  import cmic_pkg::*;

  typedef struct packed {
    cmic_host_e st;
    logic req;
    logic we;
    logic [CMIC_AW-1:0] addr;
    logic [CMIC_DW-1:0] wdata;
    logic rsp;
    logic [CMIC_DW-1:0] rdata;
  } cmic_host_s;

  cmic_host_s q;
  cmic_host_s d;
  logic [CMIC_IB_W-1:0] ib_val;
  logic [CMIC_OD_W-1:0] od_val;

  // =====================================================
  // jitter-mode setup words
  always_comb begin
    ib_val = '0;
    od_val = '0;
    ib_val[CMIC_IB_INBUFF] = 1'b1;
    ib_val[CMIC_IB_CMOS_SEL] = ja_single_ended;
    ib_val[CMIC_IB_LVDS] = !ja_single_ended && !ja_ac_coupled && ja_lvds;
    ib_val[CMIC_IB_HCSL] = !ja_single_ended && !ja_ac_coupled && !ja_lvds;
    ib_val[CMIC_IB_DCBIAS] = ja_ac_coupled && !ja_single_ended;
    ib_val[CMIC_IB_SELFBIAS] = ja_ac_coupled && ja_single_ended;
    for (int i = 0; i < CMIC_NOUT; i++) begin
      if (out_unused[i]) begin
        od_val[2*i +: 2] = CMIC_OM_HIZ;
      end else if (out_ac_coupled[i]) begin
        od_val[2*i +: 2] = CMIC_OM_HCSL;
      end else begin
        od_val[2*i +: 2] = CMIC_OM_LVDS;
      end
    end
    od_val[CMIC_OD_TERM +: CMIC_NOUT] = out_term;
  end

  // =====================================================
  // transaction sequencer: one access outstanding at a time
  always_comb begin
    d = q;
    d.rsp = 1'b0;
    case (q.st)
      CMIC_H_IDLE: begin
        if (setup_ja) begin
          d.st = CMIC_H_IB;
          d.req = 1'b1;
          d.we = 1'b1;
          d.addr = CMIC_OFS_INBUF;
          d.wdata = CMIC_DW'(ib_val);
        end else if (cmd_valid) begin
          d.st = CMIC_H_BUSY;
          d.req = 1'b1;
          d.we = cmd_we;
          d.addr = cmd_addr;
          d.wdata = cmd_wdata;
        end
      end
      CMIC_H_BUSY: begin
        if (bus.ack) begin
          d.req = 1'b0;
          d.rsp = 1'b1;
          d.rdata = bus.rdata;
          d.st = CMIC_H_IDLE;
        end
      end
      CMIC_H_IB: begin
        if (bus.ack) begin
          d.st = CMIC_H_MD;
          d.addr = CMIC_OFS_MODE;
          d.wdata = '0;
          d.wdata[CMIC_MD_STARTUP +: 2] = ja_startup;
          d.wdata[CMIC_MD_LOCK_SEL] = 1'b1;
          d.wdata[CMIC_MD_DPLL_EN] = 1'b1;
          d.wdata[CMIC_MD_REF_SEL] = 1'b1;
        end
      end
      CMIC_H_MD: begin
        if (bus.ack) begin
          d.st = CMIC_H_OD;
          d.addr = CMIC_OFS_ODRV;
          d.wdata = CMIC_DW'(od_val);
        end
      end
      default: begin
        if (bus.ack) begin
          d.req = 1'b0;
          d.rsp = 1'b1;
          d.rdata = '0;
          d.st = CMIC_H_IDLE;
        end
      end
    endcase
  end

  // =====================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q.st <= CMIC_H_IDLE;
      q.req <= 1'b0;
      q.we <= 1'b0;
      q.addr <= '0;
      q.wdata <= '0;
      q.rsp <= 1'b0;
      q.rdata <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // req is dropped while ack stands, also between the setup writes,
  // so the device never sees a repeat and every access gets a fresh request
  assign bus.req = q.req && !bus.ack;
  assign bus.we = q.we;
  assign bus.addr = q.addr;
  assign bus.wdata = q.wdata;
  assign cmd_ready = (q.st == CMIC_H_IDLE) && !setup_ja;
  assign rsp_valid = q.rsp;
  assign rsp_rdata = q.rdata;
endmodule

// [cmic_checker.sv]
module cmic_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic req,
  input wire logic we,
  input wire logic [cmic_pkg::CMIC_AW-1:0] addr,
  input wire logic [cmic_pkg::CMIC_DW-1:0] wdata,
  input wire logic ack,
  input wire logic [cmic_pkg::CMIC_DW-1:0] rdata
);
  import cmic_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================
  // register port handshake
  a_ack_next: assert property (ce && req && !ack |=> ack)
    else $error("ack missing after request");
  a_ack_pulse: assert property (ack && ce |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(ack) |-> $past(req) && !$past(ack))
    else $error("ack without request");
  // req itself falls combinationally with ack, so only its qualifiers must hold to that edge
  a_req_hold: assert property (req && !ack
      |=> $stable(we) && $stable(addr) && $stable(wdata))
    else $error("request changed before ack");
  a_req_drop: assert property (ack |-> !req)
    else $error("request kept after ack");
  // ==========================================
  // read data
  // rdata only moves together with ack, so a stale word cannot be mistaken for fresh
  a_rdata_hold: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  a_unmapped_zero: assert property (ack && !$past(we)
      && ($past(addr) > 8'h10 || ($past(addr) & 8'h03) != 8'h00) |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_width: assert property (ack && !$past(we)
      && $past(addr) == CMIC_OFS_STATUS |-> rdata[31:5] == 27'h0)
    else $error("status upper bits set");
  a_inbuf_width: assert property (ack && !$past(we)
      && $past(addr) == CMIC_OFS_INBUF |-> rdata[31:6] == 26'h0)
    else $error("input config upper bits set");
endmodule

// [cmic_tb.sv]
module cmic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cmic_pkg::*;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic reg_stable = 1'h0, bias_cal_ready = 1'h0, bias_cal_error = 1'h0, cfg_load_done = 1'h0;
  logic apll_lock = 1'h0, dpll_lock = 1'h0, cmd_valid = 1'h0, cmd_we = 1'h0, setup_ja = 1'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [31:0] cmd_wdata = 32'h0;
  logic [15:0] fb_div_ratio = 16'h1234;
  logic [31:0] xtal_trim = 32'h100, dpll_steer = 32'h0abc_def0;
  logic ja_single_ended = 1'h0, ja_ac_coupled = 1'h1, ja_lvds = 1'h0;
  logic [1:0] ja_startup = 2'h2;
  logic [3:0] out_unused = 4'h3, out_ac_coupled = 4'hc, out_term = 4'h8;
  logic [3:0] blk_rst, hcsl_term, prev;
  logic [7:0] out_mode;
  logic [31:0] fb_word, rsp_rdata, r, fexp;
  logic bias_cal_start, ref_pad_en, ref_single_ended, ref_sw_a, ref_sw_c, ref_selfbias;
  logic diff_ac_bias_enable, dpll_active, lock_sel, outputs_enabled, cmd_ready, rsp_valid;
  logic apll_ref_sel;
  wire [5:0] ib_sw = {ref_pad_en, diff_ac_bias_enable, ref_selfbias, ref_sw_c, ref_sw_a,
    ref_single_ended};
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  // ==========================================
  // design under test and checker
  cmic_if cmic_if_inst ();
  cmic_dev cmic_dev_inst (.clk_sys, .rst, .ce, .bus(cmic_if_inst.dev), .reg_stable, .blk_rst,
    .bias_cal_start, .bias_cal_ready, .bias_cal_error, .cfg_load_done, .apll_lock, .dpll_lock,
    .fb_div_ratio, .xtal_trim, .dpll_steer, .fb_word, .ref_pad_en, .ref_single_ended,
    .ref_sw_a, .ref_sw_c, .ref_selfbias, .diff_ac_bias_enable, .apll_ref_sel, .dpll_active,
    .lock_sel, .outputs_enabled, .out_mode, .hcsl_term);
  cmic_host cmic_host_inst (.clk_sys, .rst, .ce, .bus(cmic_if_inst.host), .cmd_valid, .cmd_we,
    .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .setup_ja, .ja_single_ended,
    .ja_ac_coupled, .ja_lvds, .ja_startup, .out_unused, .out_ac_coupled, .out_term);
  cmic_checker cmic_checker_inst (.clk_sys, .rst, .ce, .req(cmic_if_inst.req),
    .we(cmic_if_inst.we), .addr(cmic_if_inst.addr), .wdata(cmic_if_inst.wdata),
    .ack(cmic_if_inst.ack), .rdata(cmic_if_inst.rdata));
  always #12.5 clk_sys = ~clk_sys;
  // ==========================================
  // helpers
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_rsp();
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rsp_valid !== 1'h1 && n < 40);
    chk("rsp_valid", 32'h1, rsp_valid);
    r = rsp_rdata;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'h1;
    cmd_we <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'h0;
    wait_rsp();
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'h1;
    {reg_stable, bias_cal_ready, bias_cal_error, cfg_load_done} <= 4'h0;
    {apll_lock, dpll_lock} <= 2'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
  endtask
  // ==========================================
  // scenarios
  initial begin
    // one bring-up per startup policy, cal failure on the middle one
    for (int p = 0; p < 3; p++) begin
      do_reset();
      @(negedge clk_sys);
      chk("blk_rst", 32'hf, blk_rst);
      chk("pad_en", 32'h0, ref_pad_en);
      chk("ja_mode", 32'h0, dpll_active);
      xfer(1'h1, CMIC_OFS_MODE, 32'(p));
      chk("blk_rst", 32'hf, blk_rst);
      @(posedge clk_sys);
      reg_stable <= 1'h1;
      prev = 4'hf;
      for (int k = 1; k <= 4; k++) begin
        n = 0;
        do begin
          @(negedge clk_sys);
          n++;
        end while (blk_rst === prev && n < 40);
        prev = blk_rst;
        chk("blk_rst", 32'hf & (32'hf << k), blk_rst);
        if (k > 1) chk("rel_gap", 32'h5, n);
      end
      n = 0;
      while (bias_cal_start !== 1'h1 && n < 40) begin
        @(negedge clk_sys);
        n++;
      end
      chk("cal_start", 32'h1, bias_cal_start);
      @(posedge clk_sys);
      bias_cal_ready <= 1'h1;
      bias_cal_error <= p[0];
      cfg_load_done <= 1'h1;
      repeat (10) @(negedge clk_sys);
      chk("outs_on", 32'(p == 2), outputs_enabled);
      xfer(1'h0, CMIC_OFS_STATUS, 32'h0);
      chk("cal_bits", {p[0], 1'h1}, r[1:0]);
      @(posedge clk_sys);
      apll_lock <= (p == 0);
      dpll_lock <= (p == 1);
      repeat (5) @(negedge clk_sys);
      chk("outs_on", 32'h1, outputs_enabled);
      @(posedge clk_sys);
      {apll_lock, dpll_lock} <= 2'h0;
      repeat (5) @(negedge clk_sys);
      chk("outs_on", 32'h1, outputs_enabled);
    end
    for (int b = 0; b < 6; b++) begin
      xfer(1'h1, CMIC_OFS_INBUF, 32'h1 << b);
      chk("inbuf_sw", 32'h1 << b, ib_sw);
      xfer(1'h0, CMIC_OFS_INBUF, 32'h0);
      chk("inbuf_rd", 32'h1 << b, r);
    end
    xfer(1'h1, CMIC_OFS_FREQ, 32'h0001_0000);
    fexp = 32'((48'h1_0000 * 48'(fb_div_ratio)) >> 8) + xtal_trim;
    chk("fb_word", fexp, fb_word);
    // a setup request offered while the clock enable is low must not be seen
    @(posedge clk_sys);
    ce <= 1'h0;
    setup_ja <= 1'h1;
    repeat (3) @(posedge clk_sys);
    setup_ja <= 1'h0;
    @(negedge clk_sys);
    chk("frozen", 32'h1, {rsp_valid, dpll_active, cmd_ready});
    @(posedge clk_sys);
    ce <= 1'h1;
    setup_ja <= 1'h1;
    @(posedge clk_sys);
    setup_ja <= 1'h0;
    @(negedge clk_sys);
    chk("cmd_ready", 32'h0, cmd_ready);
    wait_rsp();
    chk("cmd_ready", 32'h1, cmd_ready);
    chk("setup_rsp", 32'h0, r);
    chk("ja_ctl", 32'hf, {apll_ref_sel, lock_sel, dpll_active, ref_pad_en});
    chk("in_bias", 32'h4, {diff_ac_bias_enable, ref_selfbias, ref_single_ended});
    chk("fb_word", dpll_steer, fb_word);
    chk("out_mode", 32'h50, out_mode);
    chk("hcsl_term", out_term, hcsl_term);
    xfer(1'h0, CMIC_OFS_MODE, 32'h0);
    chk("mode_rd", 32'h1e, r);
    xfer(1'h1, CMIC_OFS_MODE, 32'h0);
    chk("fb_word", fexp, fb_word);
    chk("ja_mode", 32'h0, {apll_ref_sel, dpll_active});
    // unmapped space and the read-only status word
    xfer(1'h1, 8'h14, 32'hffff_ffff);
    xfer(1'h0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, r);
    xfer(1'h1, CMIC_OFS_STATUS, 32'h0);
    xfer(1'h0, CMIC_OFS_STATUS, 32'h0);
    chk("status", 32'h9, r & 32'hb);
    finish_test();
  end
endmodule
